//--- stcl_pkg.sv
// Constants for the sensor trim configuration and lookup block.
// Assumes a single 10 MHz core clock and an EEPROM byte-read port outside.
package stcl_pkg;
  // ==========================================================
  // Trim register pointer codes
  localparam logic [3:0] STCL_PTR_CONFIG = 4'h0;
  localparam logic [3:0] STCL_PTR_OFFSET = 4'h1;
  localparam logic [3:0] STCL_PTR_OFF_TC = 4'h2;
  localparam logic [3:0] STCL_PTR_SPAN = 4'h3;
  localparam logic [3:0] STCL_PTR_SPAN_TC = 4'h4;
  // ==========================================================
  // Configuration word fields
  localparam int STCL_FREQ_MSB = 15;
  localparam int STCL_FREQ_LSB = 13;
  localparam int STCL_EXT_RES_BIT = 12;
  localparam int STCL_MHZ_BIT = 11;
  localparam int STCL_INV_BIT = 10;
  localparam int STCL_COARSE_POL_BIT = 9;
  localparam int STCL_COARSE_MSB = 8;
  localparam int STCL_COARSE_LSB = 6;
  localparam int STCL_GAIN_MSB = 5;
  localparam int STCL_GAIN_LSB = 2;
  localparam int STCL_OFF_POL_BIT = 1;
  localparam int STCL_OFFTC_POL_BIT = 0;
  // ==========================================================
  // Lookup table layout
  localparam logic [7:0] STCL_IDX_LOW_LAST = 8'h7F;
  localparam logic [7:0] STCL_IDX_HIGH_LAST = 8'hAF;
  localparam logic [9:0] STCL_OFF_LOW_BASE = 10'h000;
  localparam logic [9:0] STCL_SPAN_LOW_BASE = 10'h200;
  localparam logic [9:0] STCL_OFF_HIGH_BASE = 10'h100;
  localparam logic [9:0] STCL_SPAN_HIGH_BASE = 10'h1A0;
  localparam logic [7:0] STCL_LOCK_VALUE = 8'hFF;
  localparam logic [15:0] STCL_RESET_WORD = 16'h0000;
  localparam logic [7:0] STCL_GAIN_BASE = 8'd39;
  localparam logic [7:0] STCL_GAIN_STEP = 8'd13;
  typedef enum logic [2:0] {
    STCL_IDLE = 3'b000,
    STCL_OFF_LO = 3'b001,
    STCL_OFF_HI = 3'b010,
    STCL_SPAN_LO = 3'b011,
    STCL_SPAN_HI = 3'b100,
    STCL_APPLY = 3'b101
  } stcl_state_t;
endpackage : stcl_pkg

//--- stcl_trim_bank.sv
// Calibration register bank with temperature-indexed lookup fetch.
// Assumes load strobes come from the serial command decoder on core_clk_i,
// and the EEPROM byte for the registered address is taken at the next edge.
`timescale 1ns/1ps
module stcl_trim_bank (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic load_i,
  input wire logic [3:0] trim_register_pointer_i,
  input wire logic [15:0] staging_word_i,
  input wire logic lockdown_load_i,
  input wire logic [7:0] temp_index_i,
  input wire logic fetch_start_i,
  input wire logic [7:0] eeprom_data_i,
  output logic [9:0] eeprom_addr_o,
  output logic eeprom_rd_o,
  output logic [15:0] analog_config_word_o,
  output logic [15:0] lockdown_word_o,
  output logic [15:0] offset_trim_dac_o,
  output logic [15:0] offset_tempco_dac_o,
  output logic [15:0] span_trim_dac_o,
  output logic [15:0] span_tempco_dac_o,
  output logic [2:0] freq_trim_bits_o,
  output logic external_resistor_select_o,
  output logic megahertz_pin_driver_on_o,
  output logic amp_input_invert_o,
  output logic coarse_offset_polarity_o,
  output logic [2:0] coarse_offset_magnitude_o,
  output logic [3:0] amp_gain_code_o,
  output logic [7:0] amp_gain_o,
  output logic offset_trim_polarity_o,
  output logic offset_tempco_polarity_o,
  output logic serial_enable_o,
  output logic out_to_amp_o,
  output logic fetch_busy_o
);
  import stcl_pkg::*;

  // ==========================================================
  // Register load
  logic [15:0] cfg_q, off_q, offtc_q, span_q, spantc_q, lock_q;
  logic [2:0] freq_q;
  logic ext_q, mhz_q, inv_q, cpol_q, opol_q, otpol_q, ser_q, route_q;
  logic [2:0] cmag_q;
  logic [3:0] gcode_q;
  logic [7:0] gain_q;
  wire ld_cfg = load_i && (trim_register_pointer_i == STCL_PTR_CONFIG);
  wire ld_off = load_i && (trim_register_pointer_i == STCL_PTR_OFFSET);
  wire ld_offtc = load_i && (trim_register_pointer_i == STCL_PTR_OFF_TC);
  wire ld_span = load_i && (trim_register_pointer_i == STCL_PTR_SPAN);
  wire ld_spantc = load_i && (trim_register_pointer_i == STCL_PTR_SPAN_TC);
  wire locked = lock_q[7:0] == STCL_LOCK_VALUE;
  wire [7:0] gain_d = STCL_GAIN_BASE + STCL_GAIN_STEP * {4'h0, cfg_q[STCL_GAIN_MSB:STCL_GAIN_LSB]};

  // ==========================================================
  // Lookup fetch sequencer
  stcl_state_t st_q, st_d;
  logic [9:0] addr_q;
  logic [7:0] lo_q;
  logic [15:0] off_fetch_q, span_fetch_q;
  logic busy_q, rd_q;
  logic [7:0] idx_q;
  // Index held for the whole fetch, so both pairs belong to one temperature
  wire [7:0] idx_use = (st_q == STCL_IDLE) ? temp_index_i : idx_q;
  wire idx_low = idx_use <= STCL_IDX_LOW_LAST;
  wire idx_ok = temp_index_i <= STCL_IDX_HIGH_LAST;
  wire [7:0] idx_hi = idx_use - 8'h80;
  // low range pairs, low byte at even address
  // high range pairs, low byte first
  wire [9:0] off_addr = idx_low ? (STCL_OFF_LOW_BASE + {1'b0, idx_use, 1'b0})
                                : (STCL_OFF_HIGH_BASE + {1'b0, idx_hi, 1'b0});
  wire [9:0] span_addr = idx_low ? (STCL_SPAN_LOW_BASE + {1'b0, idx_use, 1'b0})
                                 : (STCL_SPAN_HIGH_BASE + {1'b0, idx_hi, 1'b0});

  always_comb begin
    st_d = st_q;
    case (st_q)
      STCL_IDLE: if (fetch_start_i && idx_ok) st_d = STCL_OFF_LO;
      STCL_OFF_LO: st_d = STCL_OFF_HI;
      STCL_OFF_HI: st_d = STCL_SPAN_LO;
      STCL_SPAN_LO: st_d = STCL_SPAN_HI;
      STCL_SPAN_HI: st_d = STCL_APPLY;
      STCL_APPLY: st_d = STCL_IDLE;
      default: st_d = STCL_IDLE;
    endcase
  end

  // Address issued one state ahead of data capture
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= STCL_IDLE;
      addr_q <= 10'h000;
      rd_q <= 1'b0;
      busy_q <= 1'b0;
      lo_q <= 8'h00;
      off_fetch_q <= 16'h0000;
      span_fetch_q <= 16'h0000;
      idx_q <= 8'h00;
    end else begin
      st_q <= st_d;
      idx_q <= idx_use;
      busy_q <= st_d != STCL_IDLE;
      rd_q <= (st_d != STCL_IDLE) && (st_d != STCL_APPLY);
      case (st_d)
        STCL_OFF_LO: addr_q <= off_addr;
        STCL_OFF_HI: addr_q <= off_addr + 10'h001;
        STCL_SPAN_LO: addr_q <= span_addr;
        STCL_SPAN_HI: addr_q <= span_addr + 10'h001;
        default: addr_q <= addr_q;
      endcase
      case (st_q)
        STCL_OFF_LO: lo_q <= eeprom_data_i;
        STCL_OFF_HI: off_fetch_q <= {eeprom_data_i, lo_q};
        STCL_SPAN_LO: lo_q <= eeprom_data_i;
        STCL_SPAN_HI: span_fetch_q <= {eeprom_data_i, lo_q};
        default: lo_q <= lo_q;
      endcase
    end
  end

  // ==========================================================
  // Calibration registers
  // five registers plus lockdown
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_q <= STCL_RESET_WORD;
      off_q <= STCL_RESET_WORD;
      offtc_q <= STCL_RESET_WORD;
      span_q <= STCL_RESET_WORD;
      spantc_q <= STCL_RESET_WORD;
      lock_q <= STCL_RESET_WORD;
    end else begin
      // whole word stored; host keeps trim bits intact
      if (ld_cfg) cfg_q <= staging_word_i;
      // lookup result wins over a same-cycle load
      if (st_q == STCL_APPLY) off_q <= off_fetch_q;
      else if (ld_off) off_q <= staging_word_i;
      if (ld_offtc) offtc_q <= staging_word_i;
      if (st_q == STCL_APPLY) span_q <= span_fetch_q;
      else if (ld_span) span_q <= staging_word_i;
      if (ld_spantc) spantc_q <= staging_word_i;
      if (lockdown_load_i) lock_q <= staging_word_i;
    end
  end

  // Decoded fields registered so every output is a flop
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      freq_q <= 3'b000;
      ext_q <= 1'b0;
      mhz_q <= 1'b0;
      inv_q <= 1'b0;
      cpol_q <= 1'b0;
      cmag_q <= 3'b000;
      gcode_q <= 4'h0;
      gain_q <= STCL_GAIN_BASE;
      opol_q <= 1'b0;
      otpol_q <= 1'b0;
      ser_q <= 1'b1;
      route_q <= 1'b0;
    end else begin
      freq_q <= cfg_q[STCL_FREQ_MSB:STCL_FREQ_LSB];
      ext_q <= cfg_q[STCL_EXT_RES_BIT];
      mhz_q <= cfg_q[STCL_MHZ_BIT];
      inv_q <= cfg_q[STCL_INV_BIT];
      cpol_q <= cfg_q[STCL_COARSE_POL_BIT];
      cmag_q <= cfg_q[STCL_COARSE_MSB:STCL_COARSE_LSB];
      gcode_q <= cfg_q[STCL_GAIN_MSB:STCL_GAIN_LSB];
      gain_q <= gain_d;
      opol_q <= cfg_q[STCL_OFF_POL_BIT];
      otpol_q <= cfg_q[STCL_OFFTC_POL_BIT];
      ser_q <= !locked;
      route_q <= locked;
    end
  end

  assign eeprom_addr_o = addr_q;
  assign eeprom_rd_o = rd_q;
  assign fetch_busy_o = busy_q;
  assign analog_config_word_o = cfg_q;
  assign lockdown_word_o = lock_q;
  assign offset_trim_dac_o = off_q;
  assign offset_tempco_dac_o = offtc_q;
  assign span_trim_dac_o = span_q;
  assign span_tempco_dac_o = spantc_q;
  assign freq_trim_bits_o = freq_q;
  assign external_resistor_select_o = ext_q;
  assign megahertz_pin_driver_on_o = mhz_q;
  assign amp_input_invert_o = inv_q;
  assign coarse_offset_polarity_o = cpol_q;
  assign coarse_offset_magnitude_o = cmag_q;
  assign amp_gain_code_o = gcode_q;
  assign amp_gain_o = gain_q;
  assign offset_trim_polarity_o = opol_q;
  assign offset_tempco_polarity_o = otpol_q;
  assign serial_enable_o = ser_q;
  assign out_to_amp_o = route_q;
endmodule : stcl_trim_bank

//--- stcl_eeprom_model.sv
// Byte-wide EEPROM model that answers the lookup fetch of the trim bank.
// Assumes the bank registers the address and samples the byte at the next edge.
`timescale 1ns/1ps
module stcl_eeprom_model (
  input wire logic eeprom_rd_i,
  input wire logic [9:0] eeprom_addr_i,
  output logic [7:0] eeprom_data_o
);
  // ==========================================================
  // Read port
  logic [7:0] pattern;
  // Pattern from the address, so the bench predicts every byte
  assign pattern = eeprom_addr_i[7:0] ^ {6'h00, eeprom_addr_i[9:8]};
  // byte pairs
  // Idle bus shows the inverse, so a stale byte is never taken for data
  assign eeprom_data_o = eeprom_rd_i ? pattern : ~pattern;
endmodule : stcl_eeprom_model

//--- stcl_trim_bank_asserts.sv
// Port checker for the trim bank, bound to every instance.
// Assumes one core clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module stcl_trim_bank_asserts (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic load_i,
  input wire logic fetch_start_i,
  input wire logic fetch_busy_o,
  input wire logic eeprom_rd_o,
  input wire logic serial_enable_o,
  input wire logic out_to_amp_o,
  input wire logic megahertz_pin_driver_on_o,
  input wire logic amp_input_invert_o,
  input wire logic [3:0] trim_register_pointer_i,
  input wire logic [3:0] amp_gain_code_o,
  input wire logic [7:0] temp_index_i,
  input wire logic [7:0] amp_gain_o,
  input wire logic [9:0] eeprom_addr_o,
  input wire logic [15:0] staging_word_i,
  input wire logic [15:0] analog_config_word_o,
  input wire logic [15:0] lockdown_word_o,
  input wire logic [15:0] offset_tempco_dac_o,
  input wire logic [15:0] span_tempco_dac_o
);
  // ==========================================================
  // Expected lookup addresses
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire logic go = fetch_start_i && !fetch_busy_o && temp_index_i <= 8'hAF;
  wire logic [9:0] off_a = {1'b0, temp_index_i[7], temp_index_i[6:0], 1'b0};
  wire logic [9:0] span_a = temp_index_i[7] ? 10'h1A0 + {2'b00, temp_index_i[6:0], 1'b0}
    : {2'b10, temp_index_i[6:0], 1'b0};
  // ==========================================================
  // Properties
  cfg_load_a: assert property (load_i && trim_register_pointer_i == 4'h0 |=>
    analog_config_word_o == $past(staging_word_i)) else $error("config load lost");
  bad_ptr_a: assert property (load_i && trim_register_pointer_i > 4'h4 |=>
    $stable(analog_config_word_o) && $stable(offset_tempco_dac_o)
    && $stable(span_tempco_dac_o)) else $error("reserved pointer wrote a register");
  lock_out_a: assert property (serial_enable_o == ($past(lockdown_word_o[7:0]) != 8'hFF)
    && out_to_amp_o == !serial_enable_o) else $error("lock decode wrong");
  gain_map_a: assert property (amp_gain_o == 8'd39 + 8'd13 * amp_gain_code_o)
    else $error("gain value wrong");
  field_copy_a: assert property ({megahertz_pin_driver_on_o, amp_input_invert_o,
    amp_gain_code_o} == {$past(analog_config_word_o[11:10]), $past(analog_config_word_o[5:2])})
    else $error("config field copy wrong");
  fetch_seq_a: assert property (go |=> (fetch_busy_o && eeprom_rd_o)[*4]
    ##1 (fetch_busy_o && !eeprom_rd_o) ##1 !fetch_busy_o) else $error("fetch sequence wrong");
  fetch_addr_a: assert property (go |=> eeprom_addr_o == $past(off_a)
    ##2 eeprom_addr_o == $past(span_a, 3)) else $error("lookup address wrong");
  idx_refuse_a: assert property (fetch_start_i && !fetch_busy_o && temp_index_i > 8'hAF
    |=> !fetch_busy_o) else $error("index beyond table accepted");
endmodule : stcl_trim_bank_asserts
bind stcl_trim_bank stcl_trim_bank_asserts stcl_trim_bank_asserts_inst (.*);

//--- testbench.sv
// Self-checking bench for the trim bank beside an EEPROM model.
// Assumes the package, bank, model and checker are compiled first.
`timescale 1ns/1ps
module testbench;
  import stcl_pkg::*;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic load_i = 1'b0;
  logic lk_i = 1'b0;
  logic go_i = 1'b0;
  logic [3:0] ptr = 4'h0;
  logic [15:0] word = 16'h0000;
  logic [7:0] idx = 8'h00;
  logic [7:0] ee_d, gain;
  logic [9:0] ee_a;
  logic ee_rd, ser, amp, busy, mhz, ext, inv, cpol, opol, tpol;
  logic [2:0] freq, cmag;
  logic [3:0] gcode;
  logic [15:0] cfg, lock, offset_trim_dac, otc, sdac, stc;
  int fails = 0;
  int checked = 0;
  stcl_trim_bank stcl_trim_bank_inst (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .load_i(load_i), .trim_register_pointer_i(ptr), .staging_word_i(word),
    .lockdown_load_i(lk_i), .temp_index_i(idx), .fetch_start_i(go_i), .eeprom_data_i(ee_d),
    .eeprom_addr_o(ee_a), .eeprom_rd_o(ee_rd), .analog_config_word_o(cfg),
    .lockdown_word_o(lock), .offset_trim_dac_o(offset_trim_dac), .offset_tempco_dac_o(otc),
    .span_trim_dac_o(sdac), .span_tempco_dac_o(stc), .freq_trim_bits_o(freq),
    .external_resistor_select_o(ext), .megahertz_pin_driver_on_o(mhz),
    .amp_input_invert_o(inv), .coarse_offset_polarity_o(cpol), .coarse_offset_magnitude_o(cmag),
    .amp_gain_code_o(gcode), .amp_gain_o(gain), .offset_trim_polarity_o(opol),
    .offset_tempco_polarity_o(tpol), .serial_enable_o(ser), .out_to_amp_o(amp),
    .fetch_busy_o(busy));
  stcl_eeprom_model stcl_eeprom_model_inst (.eeprom_rd_i(ee_rd), .eeprom_addr_i(ee_a),
    .eeprom_data_o(ee_d));
  initial begin
    forever #50 core_clk_i = ~core_clk_i;
  end
  // ==========================================================
  // Shared tasks
  task automatic tick;
    @(posedge core_clk_i);
    #1;
  endtask : tick
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  task automatic load(input logic lk, input logic [3:0] p, input logic [15:0] d);
    ptr = p;
    word = d;
    load_i = !lk;
    lk_i = lk;
    tick;
    load_i = 1'b0;
    lk_i = 1'b0;
    tick;
  endtask : load
  function automatic logic [7:0] ee(input logic [9:0] a);
    return a[7:0] ^ {6'h00, a[9:8]};
  endfunction : ee
  task automatic fetch(input logic [7:0] i, input logic [9:0] oa, input logic [9:0] sa);
    int n;
    idx = i;
    go_i = 1'b1;
    tick;
    go_i = 1'b0;
    // Index moves mid-fetch; the pairs must still match the start index
    idx = 8'hFF;
    for (n = 0; n < 20 && busy !== 1'b0; n++) tick;
    // Bounded wait: a hang counts as a mismatch and the run goes on
    chk("fetch done", {15'h0000, busy}, 16'h0000);
    chk("offset dac", offset_trim_dac, {ee(oa + 10'h1), ee(oa)});
    chk("span dac", sdac, {ee(sa + 10'h1), ee(sa)});
  endtask : fetch
  // ==========================================================
  // Scenarios
  task automatic t_config;
    // factory trim 101 kept in every word
    logic [15:0] w [4] = '{16'hA000, 16'hBFFF, 16'hB555, 16'hAAAA};
    foreach (w[i]) begin
      load(1'b0, STCL_PTR_CONFIG, w[i]);
      chk("config", cfg, w[i]);
      chk("fields", {freq, ext, mhz, inv, cpol, cmag, gcode, opol, tpol}, w[i]);
      chk("gain", {8'h00, gain}, 16'd39 + 16'd13 * w[i][5:2]);
    end
    $display("config test done");
  endtask : t_config
  task automatic t_regs;
    load(1'b0, STCL_PTR_OFFSET, 16'h1111);
    load(1'b0, STCL_PTR_OFF_TC, 16'h2222);
    load(1'b0, STCL_PTR_SPAN, 16'h3333);
    load(1'b0, STCL_PTR_SPAN_TC, 16'h4444);
    load(1'b0, 4'h5, 16'h5555);
    load(1'b0, 4'hF, 16'h6666);
    chk("regs", {offset_trim_dac[3:0], otc[3:0], sdac[3:0], stc[3:0]}, 16'h1234);
    chk("config kept", cfg, 16'hAAAA);
    $display("register test done");
  endtask : t_regs
  task automatic t_lock;
    logic [15:0] w [3] = '{16'h00FE, 16'h12FF, 16'hFF7F};
    logic e [3] = '{1'b1, 1'b0, 1'b1};
    foreach (w[i]) begin
      load(1'b1, 4'h0, w[i]);
      chk("lock word", lock, w[i]);
      chk("serial", {14'h0000, ser, amp}, {14'h0000, e[i], !e[i]});
    end
    $display("lock test done");
  endtask : t_lock
  task automatic t_reset;
    repeat (20) tick;
    sys_rst_i = 1'b0;
    chk("reset out", {gain, 6'h00, ser, amp}, {8'd39, 8'h02});
    chk("reset regs", cfg | lock | offset_trim_dac | sdac, 16'h0000);
    $display("reset test done");
  endtask : t_reset
  task automatic t_fetch;
    fetch(8'h00, 10'h000, 10'h200);
    fetch(8'h7F, 10'h0FE, 10'h2FE);
    fetch(8'h80, 10'h100, 10'h1A0);
    fetch(8'hAF, 10'h15E, 10'h1FE);
    // index beyond table leaves the dacs
    fetch(8'hB0, 10'h15E, 10'h1FE);
    $display("fetch test done");
  endtask : t_fetch
  initial begin
    t_reset;
    t_config;
    t_regs;
    t_lock;
    t_fetch;
    give_verdict;
  end
endmodule : testbench
